// ==== rtl/pot_cmd_defines.svh ====
// Purpose: Constants for the dual pot serial command decoder
// Assumes: Frames framed by chip select, bits taken on serial clock rising edge
// Notes: Header of definitions only
`ifndef POT_CMD_DEFINES_SVH
`define POT_CMD_DEFINES_SVH
`define TYPE_ID        4'h5
`define OP_STORE       4'hE
`define OP_LOAD        4'hD
`define OP_STEP        4'h2
`define OP_STATUS      4'h5
`define SEL_STATUS     4'h1
`define WIPER_RESET    8'h00
`define WRITE_TIME_US  10
`define WRITE_CYCLES   ((`WRITE_TIME_US * 1000) / 40)
`endif

// ==== rtl/pot_cmd_pkg.sv ====
// Purpose: Types for the pot command decoder
// Assumes: Constants live in pot_cmd_defines.svh
// Notes: None
package pot_cmd_pkg;
	typedef enum logic [1:0] {
		ST_HEADER = 2'b00,
		ST_STEP   = 2'b01,
		ST_STATUS = 2'b10,
		ST_IGNORE = 2'b11
	} phase_t;
	typedef struct packed {
		logic       cs_n;
		logic       sck;
		logic       sdi;
	} serial_in_t;
endpackage : pot_cmd_pkg

// ==== rtl/nv_write_timer.sv ====
// Purpose: Times the nonvolatile write cycle and raises busy
// Assumes: Start is a one-cycle pulse
// Notes: A new start during a write restarts the count
`timescale 1ns/1ps
`include "pot_cmd_defines.svh"
module nv_write_timer #(
	parameter int CYCLES = `WRITE_CYCLES
) (
	input  wire logic clock_i,   // System clock
	input  wire logic rst_n_i,   // Async reset, active low
	input  wire logic start_i,   // Begin write cycle
	output logic      busy_o     // Write in progress
);
	typedef struct packed {
		logic [31:0] count;
		logic        busy;
	} timer_t;
	timer_t state;
	timer_t next_state;

	// Count down while busy
	always_comb begin
		next_state = state;
		if (start_i) begin
			next_state.count = 32'(CYCLES);
			next_state.busy = 1'b1;
		end else if (state.busy) begin
			if (state.count <= 32'h00000001) begin
				next_state.busy = 1'b0;
				next_state.count = 32'h00000000;
			end else begin
				next_state.count = state.count - 32'h00000001;
			end
		end
	end

	// State register
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign busy_o = state.busy;

	AST_BUSY_AFTER_START: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		start_i |=> busy_o) else $error("busy not raised after start");
endmodule : nv_write_timer

// ==== rtl/pot_cmd_decoder.sv ====
// Purpose: Serial command decoder for wiper transfer, step and status read
// Assumes: Chip select, serial clock and data synchronous to clock_i
// Notes: Read and write data register commands are outside this block
`timescale 1ns/1ps
`include "pot_cmd_defines.svh"
module pot_cmd_decoder #(
	parameter int WRITE_CYCLES = `WRITE_CYCLES,
	parameter int WIDTH        = 8
) (
	input  wire logic                     clock_i,       // System clock
	input  wire logic                     rst_n_i,       // Async reset, active low
	input  wire pot_cmd_pkg::serial_in_t  serial_i,      // Chip select, clock, data
	input  wire logic                     chip_address_high_i, // Strap A high
	input  wire logic                     chip_address_low_i,  // Strap A low
	output logic                          sdo_o,         // Serial data out
	output logic                          sdo_oe_o,      // Serial out drive enable
	output logic [WIDTH-1:0]              wiper_0_o,     // Pot 0 wiper position
	output logic [WIDTH-1:0]              wiper_1_o,     // Pot 1 wiper position
	output logic [7:0]                    device_status_o // Status byte
);
	import pot_cmd_pkg::*;

	typedef struct packed {
		phase_t           phase;
		logic             cs_d;
		logic             sck_d;
		logic [4:0]       bit_count;
		logic [15:0]      shift;
		logic             pot;
		logic [7:0]       status_shift;
		logic             sdo;
		logic             sdo_oe;
		logic [1:0][WIDTH-1:0] wiper;
		logic [1:0][3:0][WIDTH-1:0] setting;
		logic             start_write;
	} core_t;
	core_t state;
	core_t next_state;
	logic  write_in_progress_flag;

	wire cs_n = serial_i.cs_n;
	wire sck_rise = serial_i.sck && !state.sck_d;
	wire sck_fall = !serial_i.sck && state.sck_d;
	wire cs_fall = !cs_n && state.cs_d;
	wire cs_rise = cs_n && !state.cs_d;

	// Saturating one-tap step
	function automatic logic [WIDTH-1:0] step_tap(input logic [WIDTH-1:0] v, input logic up);
		if (up) begin
			step_tap = (&v) ? v : v + WIDTH'(1);
		end else begin
			step_tap = (v == '0) ? v : v - WIDTH'(1);
		end
	endfunction : step_tap

	// Frame decode and command execution
	always_comb begin
		logic [15:0] hdr;
		hdr = '0;
		next_state = state;
		next_state.cs_d = cs_n;
		next_state.sck_d = serial_i.sck;
		next_state.start_write = 1'b0;
		if (cs_fall) begin
			next_state.phase = ST_HEADER;
			next_state.bit_count = '0;
			next_state.sdo_oe = 1'b0;
		end else if (cs_n) begin
			next_state.sdo_oe = 1'b0;
		end else if (sck_rise) begin
			unique case (state.phase)
				ST_HEADER: begin
					hdr = {state.shift[14:0], serial_i.sdi};
					next_state.shift = hdr;
					next_state.bit_count = state.bit_count + 5'h01;
					if (state.bit_count == 5'h0F) begin
						next_state.phase = ST_IGNORE;
						next_state.pot = hdr[0];
						if (hdr[15:12] == `TYPE_ID && hdr[11:10] == 2'b00 &&
								hdr[9] == chip_address_high_i && hdr[8] == chip_address_low_i) begin
							if (hdr[7:4] == `OP_STEP && hdr[1] == 1'b0) begin
								next_state.phase = ST_STEP;
							end else if (hdr[7:4] == `OP_STATUS && hdr[3:0] == `SEL_STATUS) begin
								next_state.phase = ST_STATUS;
								next_state.status_shift = {7'h00, write_in_progress_flag};
								next_state.bit_count = '0;
							end
						end
					end
				end
				ST_STEP: begin
					next_state.wiper[state.pot] = step_tap(state.wiper[state.pot], serial_i.sdi);
				end
				ST_IGNORE: begin
					// Extra pulses past the header spoil a store or load
					next_state.bit_count = 5'h11;
				end
				ST_STATUS: begin
				end
			endcase
		end else if (sck_fall && state.phase == ST_STATUS) begin
			// Shift status out, most significant first
			if (state.bit_count < 5'h08) begin
				next_state.sdo = state.status_shift[7];
				next_state.sdo_oe = 1'b1;
				next_state.status_shift = {state.status_shift[6:0], 1'b0};
				next_state.bit_count = state.bit_count + 5'h01;
			end else begin
				next_state.sdo_oe = 1'b0;
			end
		end
		// Transfers complete at chip select rise
		if (cs_rise && state.phase == ST_IGNORE && state.bit_count == 5'h10 &&
				state.shift[15:12] == `TYPE_ID && state.shift[11:10] == 2'b00 &&
				state.shift[9] == chip_address_high_i && state.shift[8] == chip_address_low_i &&
				state.shift[1] == 1'b0) begin
			// Wiper into chosen setting, then write cycle
			if (state.shift[7:4] == `OP_STORE) begin
				next_state.setting[state.shift[0]][state.shift[3:2]] = state.wiper[state.shift[0]];
				next_state.start_write = 1'b1;
			end else if (state.shift[7:4] == `OP_LOAD) begin
				next_state.wiper[state.shift[0]] = state.setting[state.shift[0]][state.shift[3:2]];
			end
		end
	end

	// State register
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= '0;
			state.cs_d <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// Nonvolatile write timer
	nv_write_timer #(.CYCLES(WRITE_CYCLES)) u_timer (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.start_i (state.start_write),
		.busy_o  (write_in_progress_flag)
	);

	assign sdo_o = state.sdo;
	assign sdo_oe_o = state.sdo_oe;
	assign wiper_0_o = state.wiper[0];
	assign wiper_1_o = state.wiper[1];
	assign device_status_o = {7'h00, write_in_progress_flag};

	AST_STEP_SAT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state.phase == ST_STEP && !cs_n && sck_rise && serial_i.sdi && (&state.wiper[state.pot]))
		|=> (&state.wiper[state.pot])) else $error("wiper wrapped above top");
	AST_STATUS_HIGH_ZERO: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		device_status_o[7:1] == 7'h00) else $error("status upper bits not zero");
	AST_STORE_BUSY: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		state.start_write |=> write_in_progress_flag) else $error("no write after store");
	AST_NO_OE_DESELECT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		cs_n && state.cs_d |=> !sdo_oe_o) else $error("drive while deselected");

	// Sixteenth header bit arriving; shift holds the first fifteen
	sequence hdr_done_seq;
		state.phase == ST_HEADER && !cs_n && !cs_fall && sck_rise &&
			state.bit_count == 5'h0F;
	endsequence

	// Identifier and address of a header whose sixteenth bit is arriving match this device
	sequence hdr_match_seq;
		state.shift[14:11] == `TYPE_ID && state.shift[10:9] == 2'b00 &&
			state.shift[8] == chip_address_high_i && state.shift[7] == chip_address_low_i;
	endsequence

	// Clean sixteen-bit frame closing on chip select rise
	sequence close_ok_seq;
		cs_rise && state.phase == ST_IGNORE && state.bit_count == 5'h10 &&
			state.shift[15:12] == `TYPE_ID && state.shift[11:10] == 2'b00 &&
			state.shift[9] == chip_address_high_i && state.shift[8] == chip_address_low_i &&
			state.shift[1] == 1'b0;
	endsequence

	// Closing frame carries the store opcode
	sequence store_close_seq;
		close_ok_seq ##0 (state.shift[7:4] == `OP_STORE);
	endsequence

	// Closing frame carries the load opcode
	sequence load_close_seq;
		close_ok_seq ##0 (state.shift[7:4] == `OP_LOAD);
	endsequence

	// Step request below the lowest tap
	sequence floor_down_seq;
		state.phase == ST_STEP && !cs_n && sck_rise && !serial_i.sdi &&
			(state.wiper[state.pot] == '0);
	endsequence

	// Foreign address leaves the device idle for the frame
	AST_FOREIGN_IGNORED: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		hdr_done_seq ##0 (state.shift[8] != chip_address_high_i ||
			state.shift[7] != chip_address_low_i)
		|=> state.phase == ST_IGNORE) else $error("foreign frame accepted");

	// Store copies the wiper and starts the write timer
	AST_STORE_SETTING: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		store_close_seq
		|=> (state.setting[state.shift[0]][state.shift[3:2]] == state.wiper[state.shift[0]])
			&& state.start_write) else $error("store did not copy wiper");

	// Load copies the chosen setting into the wiper
	AST_LOAD_WIPER: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		load_close_seq
		|=> state.wiper[state.shift[0]] == state.setting[state.shift[0]][state.shift[3:2]])
		else $error("load did not copy setting");

	// Status header loads seven zeros and the busy flag
	AST_STATUS_LOAD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		hdr_done_seq ##0 hdr_match_seq ##0 (state.shift[6:3] == `OP_STATUS &&
			{state.shift[2:0], serial_i.sdi} == `SEL_STATUS)
		|=> state.phase == ST_STATUS && state.status_shift[7:1] == 7'h00 &&
			state.status_shift[0] == $past(write_in_progress_flag))
		else $error("status byte not loaded");

	// Wiper holds at the lowest tap on a down request
	AST_STEP_FLOOR: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		floor_down_seq |=> (state.wiper[state.pot] == '0)) else $error("wiper wrapped below floor");
endmodule : pot_cmd_decoder

// ==== sim/spi_host.sv ====
// Purpose: Serial host that frames commands for the pot decoder
// Assumes: Each serial clock phase lasts four system clocks
// Notes: Data line is inverted once released
`timescale 1ns/1ps
module spi_host (
	input  wire logic               clock_i, // System clock
	input  wire logic               sdo_i,   // Serial data from device
	output pot_cmd_pkg::serial_in_t ser_o    // Select, clock, data
);
	import pot_cmd_pkg::*;
	initial ser_o = 3'b100;
	// Hold one serial clock phase
	task automatic half;
		repeat (4) @(negedge clock_i);
	endtask : half
	// Header, then n extra pulses carrying dir, capturing returned bits
	task automatic frame(input logic [15:0] hdr, input int n, input logic dir,
		output logic [7:0] rx);
		rx = 8'h00;
		@(negedge clock_i);
		ser_o.cs_n = 1'b0;
		half();
		for (int i = 0; i < 16 + n; i++) begin
			ser_o.sdi = (i < 16) ? hdr[15 - i] : dir;
			half();
			rx = {rx[6:0], sdo_i};
			ser_o.sck = 1'b1;
			half();
			ser_o.sck = 1'b0;
		end
		half();
		ser_o.cs_n = 1'b1;
		ser_o.sdi  = ~ser_o.sdi;
		half();
	endtask : frame
endmodule : spi_host

// ==== sim/pot_serial_instruction_decoder_test.sv ====
// Purpose: Self-checking bench for the pot command decoder
// Assumes: Host model drives the serial pins at falling clock edges
// Notes: Write timer lengthened to 400 cycles from the default 250
`timescale 1ns/1ps
`include "pot_cmd_defines.svh"
module pot_serial_instruction_decoder_test;
	import pot_cmd_pkg::*;
	logic       clock_i = 1'b0;
	logic       rst_n_i = 1'b0;
	logic [1:0] addr    = 2'b00;
	serial_in_t ser;
	logic       sdo;
	logic       oe;
	logic [7:0] w0, w1, st, rx;
	int         fail_count = 0;
	int         total_checks = 0;
	int         n, k;
	// Clock generation
	always #20 clock_i = ~clock_i;
	pot_cmd_decoder #(.WRITE_CYCLES(400), .WIDTH(8)) u_dut (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .serial_i(ser),
		.chip_address_high_i(addr[1]), .chip_address_low_i(addr[0]),
		.sdo_o(sdo), .sdo_oe_o(oe), .wiper_0_o(w0), .wiper_1_o(w1),
		.device_status_o(st));
	spi_host u_host (.clock_i(clock_i), .sdo_i(sdo), .ser_o(ser));
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	function automatic logic [15:0] hdr(input logic [3:0] op, input logic [1:0] rs,
		input logic p, input logic [1:0] a);
		return {`TYPE_ID, 2'b00, a, op, rs, 1'b0, p};
	endfunction : hdr
	function automatic logic [7:0] sat(input int v);
		return (v > 255) ? 8'hFF : (v < 0) ? 8'h00 : v[7:0];
	endfunction : sat
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	// Watchdog
	initial begin
		#1000000;
		fail_count++;
		wrap_up();
	end
	// Main sequence
	initial begin
		void'($urandom(26));
		@(negedge clock_i);
		addr = 2'($urandom);
		repeat (3) @(negedge clock_i);
		rst_n_i = 1'b1;
		chk("wiper0", 8'h00, w0);
		chk("status", 8'h00, st);
		repeat (2) @(negedge clock_i);
		u_host.frame(hdr(`OP_STEP, 2'b00, 1'b0, addr), 3, 1'b0, rx);
		chk("wiper0 floor", sat(-3), w0);
		n = 1 + ($urandom % 20);
		u_host.frame(hdr(`OP_STEP, 2'b11, 1'b1, addr), n, 1'b1, rx);
		chk("wiper1 up", sat(n), w1);
		chk("wiper0 kept", 8'h00, w0);
		$display("test step done");
		u_host.frame(hdr(`OP_STEP, 2'b00, 1'b1, ~addr), 5, 1'b1, rx);
		u_host.frame(hdr(`OP_STEP, 2'b00, 1'b1, addr) ^ 16'h8000, 5, 1'b1, rx);
		chk("wiper1 foreign", sat(n), w1);
		$display("test address done");
		k = $urandom % 4;
		u_host.frame(hdr(`OP_STORE, 2'(k), 1'b1, addr), 0, 1'b0, rx);
		chk("status reg busy", 8'h01, st);
		u_host.frame(hdr(`OP_STATUS, 2'b00, 1'b1, addr), 8, 1'b0, rx);
		chk("status read busy", 8'h01, rx);
		repeat (400) @(negedge clock_i);
		u_host.frame(hdr(`OP_STATUS, 2'b00, 1'b1, addr), 8, 1'b1, rx);
		chk("status read idle", 8'h00, rx);
		chk("drive after deselect", 8'h00, {7'h00, oe});
		$display("test store done");
		u_host.frame(hdr(`OP_STEP, 2'b00, 1'b1, addr), 300, 1'b1, rx);
		chk("wiper1 ceiling", sat(n + 300), w1);
		u_host.frame(hdr(`OP_LOAD, 2'(k), 1'b1, addr), 0, 1'b0, rx);
		chk("wiper1 load", sat(n), w1);
		chk("wiper0 untouched", 8'h00, w0);
		$display("test load done");
		wrap_up();
	end
endmodule : pot_serial_instruction_decoder_test
